/* tpl_pkg.sv */
// package: register map, field layout, command codes and types of the block
package tpl_pkg;
   localparam int TPL_NUM_PROT = 3;
   localparam int TPL_DOT = 0;
   localparam int TPL_DIE = 1;
   localparam int TPL_CUT = 2;

   localparam logic [7:0] TPL_OFS_PROT_EN = 8'h00;
   localparam logic [7:0] TPL_OFS_DSG_FET = 8'h04;
   localparam logic [7:0] TPL_OFS_CHG_FET = 8'h08;
   localparam logic [7:0] TPL_OFS_DOT_CFG = 8'h0C;
   localparam logic [7:0] TPL_OFS_DIE_CFG = 8'h10;
   localparam logic [7:0] TPL_OFS_CUT_CFG = 8'h14;
   localparam logic [7:0] TPL_OFS_CMD = 8'h18;
   localparam logic [7:0] TPL_OFS_STATUS = 8'h1C;

   // fet configuration bits: bit 0 own protection, bit 1 die protection
   localparam int TPL_FET_OWN_BIT = 0;
   localparam int TPL_FET_DIE_BIT = 1;

   // protection configuration word fields
   localparam int TPL_CFG_TRIP_LSB = 0;
   localparam int TPL_CFG_REC_LSB = 8;
   localparam int TPL_CFG_DLY_LSB = 16;

   // command word: code in [15:0], argument bits in [23:16]
   localparam logic [15:0] TPL_CMD_REGULATOR_CONTROL = 16'h0069;
   localparam logic [15:0] TPL_CMD_PROTECTION_RECOVERY = 16'h009B;
   localparam int TPL_CMD_ARG_LSB = 16;
   localparam int TPL_CONTINUOUS_BIAS_BIT = 0;
   localparam int TPL_TEMPERATURE_RECOVERY_BIT = 0;

   // status word fields
   localparam int TPL_ST_ALERT_LSB = 0;
   localparam int TPL_ST_FAULT_LSB = 8;
   localparam int TPL_ST_DSG_OFF_BIT = 16;
   localparam int TPL_ST_CHG_OFF_BIT = 17;
   localparam int TPL_ST_BIAS_BIT = 18;

   // threshold steps are fractions of the 1v8 reference rail
   localparam int TPL_DOT_STEP_DIVISOR = 359;
   localparam int TPL_CUT_STEP_DIVISOR = 252;
   localparam int TPL_DIE_MIN_C = 25;
   localparam int TPL_DIE_MAX_C = 150;

   localparam logic [2:0] TPL_EN_RESET = 3'h0;
   localparam logic [1:0] TPL_FET_RESET = 2'h0;
   localparam logic [23:0] TPL_CFG_RESET = 24'h000000;

   typedef struct packed {
      logic [7:0] delay;
      logic [7:0] recovery;
      logic [7:0] trip;
   } tpl_prot_cfg_t;
endpackage : tpl_pkg

/* tpl_temp_protect.sv */
// temperature protection block: three protections behind an apb slave
// Behaviour
// - discharge overtemp alerts when sense below threshold
// - discharge overtemp thresholds 8-bit, ref/359 steps
// - discharge overtemp evaluated only when enabled
// - discharge overtemp faults after programmed interval count
// - discharge overtemp fault cuts discharge drive if selected
// - discharge overtemp recovers when sense reaches recovery
// - zero recovery needs host recovery command
// - trip clears alert, sets fault, applies fet
// - bias only while evaluating unless continuous
// - die overtemp alerts above threshold, 25-150C
// - die overtemp evaluated only when enabled
// - die overtemp faults after programmed interval count
// - die overtemp fault cuts both drives per config
// - die overtemp recovers at or below recovery
// - charge undertemp alerts when sense above threshold
// - charge undertemp thresholds 8-bit, ref/252 steps
// - charge undertemp evaluated only when enabled
// - charge undertemp faults after programmed interval count
// - charge undertemp fault cuts charge drive if selected
// - charge undertemp recovers when sense falls to recovery
// - alert zero when absent, one while pending
//
// Implementation choices: the APB slave port and the register addresses.
module tpl_temp_protect #(
   parameter int CODE_W = 8
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic EVAL_WINDOW,
   input wire logic EVAL_TICK,
   input wire logic [CODE_W-1:0] THERMISTOR_SENSE_CODE,
   input wire logic [CODE_W-1:0] DIE_TEMP_CODE,
   output logic THERMISTOR_BIAS_EN,
   output logic DISCHARGE_FET_DRIVE_OFF,
   output logic CHARGE_FET_DRIVE_OFF,
   output logic [tpl_pkg::TPL_NUM_PROT-1:0] ALERT_FLAGS,
   output logic [tpl_pkg::TPL_NUM_PROT-1:0] FAULT_FLAGS
);
   import tpl_pkg::*;

   logic [2:0] prot_en_reg;
   logic [1:0] dsg_fet_reg;
   logic [1:0] chg_fet_reg;
   tpl_prot_cfg_t cfg_reg [TPL_NUM_PROT];
   logic continuous_bias_reg;
   logic temp_recovery_cmd;
   logic [31:0] prdata_reg;
   logic [31:0] rd_next;
   logic addr_ok;
   logic wr_acc;
   logic alert_reg [TPL_NUM_PROT];
   logic fault_reg [TPL_NUM_PROT];
   logic [7:0] cnt_reg [TPL_NUM_PROT];
   logic bias_reg;
   logic dsg_off_reg;
   logic chg_off_reg;

   // trip condition: discharge overtemp and die overtemp compare differently
   function automatic logic trip_cond(input int idx,
                                      input logic [CODE_W-1:0] meas,
                                      input logic [7:0] thr);
      logic r;
      r = 1'b0;
      case (idx)
         TPL_DOT: r = meas < CODE_W'(thr);
         TPL_DIE: r = meas > CODE_W'(thr);
         default: r = meas > CODE_W'(thr);
      endcase
      return r;
   endfunction : trip_cond

   // recovery condition against the separate recovery setting
   function automatic logic rec_cond(input int idx,
                                     input logic [CODE_W-1:0] meas,
                                     input logic [7:0] thr);
      logic r;
      r = 1'b0;
      case (idx)
         TPL_DOT: r = meas >= CODE_W'(thr);
         TPL_DIE: r = meas <= CODE_W'(thr);
         default: r = meas <= CODE_W'(thr);
      endcase
      return r;
   endfunction : rec_cond

   function automatic logic map_hit(input logic [7:0] a);
      logic r;
      r = 1'b0;
      case (a)
         TPL_OFS_PROT_EN, TPL_OFS_DSG_FET, TPL_OFS_CHG_FET,
         TPL_OFS_DOT_CFG, TPL_OFS_DIE_CFG, TPL_OFS_CUT_CFG,
         TPL_OFS_CMD, TPL_OFS_STATUS: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : map_hit

   // apb: zero wait states, read data captured in the setup cycle
   assign addr_ok = map_hit(PADDR);
   assign PREADY = PSEL & PENABLE;
   assign PSLVERR = PSEL & PENABLE & ~addr_ok;
   assign PRDATA = prdata_reg;
   assign wr_acc = PSEL & PENABLE & PWRITE & addr_ok;

   always_comb begin
      rd_next = 32'h00000000;
      case (PADDR)
         TPL_OFS_PROT_EN: rd_next = {29'h0, prot_en_reg};
         TPL_OFS_DSG_FET: rd_next = {30'h0, dsg_fet_reg};
         TPL_OFS_CHG_FET: rd_next = {30'h0, chg_fet_reg};
         TPL_OFS_DOT_CFG: rd_next = {8'h00, cfg_reg[TPL_DOT]};
         TPL_OFS_DIE_CFG: rd_next = {8'h00, cfg_reg[TPL_DIE]};
         TPL_OFS_CUT_CFG: rd_next = {8'h00, cfg_reg[TPL_CUT]};
         TPL_OFS_STATUS: begin
            rd_next[TPL_ST_ALERT_LSB +: 3] = ALERT_FLAGS;
            rd_next[TPL_ST_FAULT_LSB +: 3] = FAULT_FLAGS;
            rd_next[TPL_ST_DSG_OFF_BIT] = dsg_off_reg;
            rd_next[TPL_ST_CHG_OFF_BIT] = chg_off_reg;
            rd_next[TPL_ST_BIAS_BIT] = bias_reg;
         end
         default: rd_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         prdata_reg <= 32'h00000000;
      end else if (PSEL & ~PENABLE & ~PWRITE) begin
         prdata_reg <= rd_next;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         prot_en_reg <= TPL_EN_RESET;
         dsg_fet_reg <= TPL_FET_RESET;
         chg_fet_reg <= TPL_FET_RESET;
         cfg_reg[TPL_DOT] <= TPL_CFG_RESET;
         cfg_reg[TPL_DIE] <= TPL_CFG_RESET;
         cfg_reg[TPL_CUT] <= TPL_CFG_RESET;
      end else if (wr_acc) begin
         case (PADDR)
            TPL_OFS_PROT_EN: prot_en_reg <= PWDATA[2:0];
            TPL_OFS_DSG_FET: dsg_fet_reg <= PWDATA[1:0];
            TPL_OFS_CHG_FET: chg_fet_reg <= PWDATA[1:0];
            TPL_OFS_DOT_CFG: cfg_reg[TPL_DOT] <= PWDATA[23:0];
            TPL_OFS_DIE_CFG: cfg_reg[TPL_DIE] <= PWDATA[23:0];
            TPL_OFS_CUT_CFG: cfg_reg[TPL_CUT] <= PWDATA[23:0];
            default: prot_en_reg <= prot_en_reg;
         endcase
      end
   end

   // command register: write-only, acts on the write itself
   assign temp_recovery_cmd = wr_acc && PADDR == TPL_OFS_CMD
      && PWDATA[15:0] == TPL_CMD_PROTECTION_RECOVERY
      && PWDATA[TPL_CMD_ARG_LSB + TPL_TEMPERATURE_RECOVERY_BIT];

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         continuous_bias_reg <= 1'b0;
      end else if (wr_acc && PADDR == TPL_OFS_CMD
                   && PWDATA[15:0] == TPL_CMD_REGULATOR_CONTROL) begin
         continuous_bias_reg <=
            PWDATA[TPL_CMD_ARG_LSB + TPL_CONTINUOUS_BIAS_BIT];
      end
   end

   // pullup burns current, so by default it is on only while measuring
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         bias_reg <= 1'b0;
      end else begin
         bias_reg <= continuous_bias_reg | EVAL_WINDOW;
      end
   end
   assign THERMISTOR_BIAS_EN = bias_reg;

   genvar gi;
   generate
      for (gi = 0; gi < TPL_NUM_PROT; gi++) begin : g_prot
         logic [CODE_W-1:0] meas;
         logic cond;
         logic rec_ok;
         assign meas = (gi == TPL_DIE) ? DIE_TEMP_CODE
                                       : THERMISTOR_SENSE_CODE;
         assign cond = trip_cond(gi, meas, cfg_reg[gi].trip);
         // zero recovery setting blocks autonomous recovery
         assign rec_ok = cfg_reg[gi].recovery != 8'h00
            && rec_cond(gi, meas, cfg_reg[gi].recovery);

         // persistence count per tick; >= so a delay lowered mid-count trips
         always_ff @(posedge REF_CLK) begin
            if (RST) begin
               alert_reg[gi] <= 1'b0;
               cnt_reg[gi] <= 8'h00;
            end else if (EVAL_TICK) begin
               if (!prot_en_reg[gi] || fault_reg[gi] || !cond) begin
                  alert_reg[gi] <= 1'b0;
                  cnt_reg[gi] <= 8'h00;
               end else if (cnt_reg[gi] >= cfg_reg[gi].delay) begin
                  alert_reg[gi] <= 1'b0;
                  cnt_reg[gi] <= 8'h00;
               end else begin
                  alert_reg[gi] <= 1'b1;
                  cnt_reg[gi] <= cnt_reg[gi] + 8'h01;
               end
            end
         end

         // fault latch; a trip in the same cycle as host recovery wins
         always_ff @(posedge REF_CLK) begin
            if (RST) begin
               fault_reg[gi] <= 1'b0;
            end else if (EVAL_TICK && prot_en_reg[gi] && !fault_reg[gi]
                         && cond && cnt_reg[gi] >= cfg_reg[gi].delay) begin
               fault_reg[gi] <= 1'b1;
            end else if (temp_recovery_cmd) begin
               fault_reg[gi] <= 1'b0;
            end else if (EVAL_TICK && fault_reg[gi] && rec_ok) begin
               fault_reg[gi] <= 1'b0;
            end
         end

         assign ALERT_FLAGS[gi] = alert_reg[gi];
         assign FAULT_FLAGS[gi] = fault_reg[gi];
      end
   endgenerate

   // fet drive cut-off, each source gated by its autonomous-control bit
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         dsg_off_reg <= 1'b0;
      end else begin
         dsg_off_reg <=
            (fault_reg[TPL_DOT] & dsg_fet_reg[TPL_FET_OWN_BIT])
            | (fault_reg[TPL_DIE] & dsg_fet_reg[TPL_FET_DIE_BIT]);
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         chg_off_reg <= 1'b0;
      end else begin
         chg_off_reg <=
            (fault_reg[TPL_CUT] & chg_fet_reg[TPL_FET_OWN_BIT])
            | (fault_reg[TPL_DIE] & chg_fet_reg[TPL_FET_DIE_BIT]);
      end
   end
   assign DISCHARGE_FET_DRIVE_OFF = dsg_off_reg;
   assign CHARGE_FET_DRIVE_OFF = chg_off_reg;

   // checks
   property p_dot_alert;
      @(posedge REF_CLK) disable iff (RST)
      EVAL_TICK && prot_en_reg[TPL_DOT] && !fault_reg[TPL_DOT]
      && THERMISTOR_SENSE_CODE < CODE_W'(cfg_reg[TPL_DOT].trip)
      && cfg_reg[TPL_DOT].delay != 8'h00 && cnt_reg[TPL_DOT] == 8'h00
      |=> ALERT_FLAGS[TPL_DOT] && !FAULT_FLAGS[TPL_DOT];
   endproperty
   a_dot_alert: assert property (p_dot_alert)
      else $error("discharge overtemp alert not raised");

   property p_disabled_quiet;
      @(posedge REF_CLK) disable iff (RST)
      EVAL_TICK && !prot_en_reg[TPL_CUT] |=> !ALERT_FLAGS[TPL_CUT];
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet)
      else $error("disabled charge undertemp raised alert");

   property p_die_en;
      @(posedge REF_CLK) disable iff (RST)
      !prot_en_reg[TPL_DIE] && !FAULT_FLAGS[TPL_DIE]
      && !temp_recovery_cmd |=> !FAULT_FLAGS[TPL_DIE];
   endproperty
   a_die_en: assert property (p_die_en)
      else $error("disabled die overtemp faulted");

   property p_zero_delay;
      @(posedge REF_CLK) disable iff (RST)
      EVAL_TICK && prot_en_reg[TPL_CUT] && !fault_reg[TPL_CUT]
      && THERMISTOR_SENSE_CODE > CODE_W'(cfg_reg[TPL_CUT].trip)
      && cfg_reg[TPL_CUT].delay == 8'h00
      |=> FAULT_FLAGS[TPL_CUT] && !ALERT_FLAGS[TPL_CUT];
   endproperty
   a_zero_delay: assert property (p_zero_delay)
      else $error("zero delay did not trip at once");

   property p_trip_clears_alert;
      @(posedge REF_CLK) disable iff (RST)
      $rose(FAULT_FLAGS[TPL_DIE]) |-> !ALERT_FLAGS[TPL_DIE]
      && $past(ALERT_FLAGS[TPL_DIE]) == (cfg_reg[TPL_DIE].delay != 8'h00);
   endproperty
   a_trip_clears_alert: assert property (p_trip_clears_alert)
      else $error("trip did not follow alert correctly");

   property p_dsg_cut;
      @(posedge REF_CLK) disable iff (RST)
      FAULT_FLAGS[TPL_DOT] && dsg_fet_reg[TPL_FET_OWN_BIT]
      |=> DISCHARGE_FET_DRIVE_OFF;
   endproperty
   a_dsg_cut: assert property (p_dsg_cut)
      else $error("discharge drive not cut on fault");

   property p_chg_cut;
      @(posedge REF_CLK) disable iff (RST)
      ##1 CHARGE_FET_DRIVE_OFF |-> $past(
         (fault_reg[TPL_CUT] & chg_fet_reg[TPL_FET_OWN_BIT])
         | (fault_reg[TPL_DIE] & chg_fet_reg[TPL_FET_DIE_BIT]));
   endproperty
   a_chg_cut: assert property (p_chg_cut)
      else $error("charge drive cut without cause");

   property p_no_auto_rec;
      @(posedge REF_CLK) disable iff (RST)
      FAULT_FLAGS[TPL_DOT] && cfg_reg[TPL_DOT].recovery == 8'h00
      && !temp_recovery_cmd |=> FAULT_FLAGS[TPL_DOT];
   endproperty
   a_no_auto_rec: assert property (p_no_auto_rec)
      else $error("fault recovered with zero recovery setting");

   property p_rec;
      @(posedge REF_CLK) disable iff (RST)
      EVAL_TICK && fault_reg[TPL_CUT] && cfg_reg[TPL_CUT].recovery != 8'h00
      && THERMISTOR_SENSE_CODE <= CODE_W'(cfg_reg[TPL_CUT].recovery)
      |=> !FAULT_FLAGS[TPL_CUT];
   endproperty
   a_rec: assert property (p_rec)
      else $error("charge undertemp did not recover");

   property p_bias;
      @(posedge REF_CLK) disable iff (RST)
      !continuous_bias_reg && !EVAL_WINDOW ##1 !continuous_bias_reg
      |-> !THERMISTOR_BIAS_EN;
   endproperty
   a_bias: assert property (p_bias)
      else $error("bias on outside evaluation");

   property p_dot_trip;
      @(posedge REF_CLK) disable iff (RST)
      EVAL_TICK && prot_en_reg[TPL_DOT] && !fault_reg[TPL_DOT]
      && THERMISTOR_SENSE_CODE < CODE_W'(cfg_reg[TPL_DOT].trip)
      && cnt_reg[TPL_DOT] >= cfg_reg[TPL_DOT].delay
      |=> FAULT_FLAGS[TPL_DOT] && !ALERT_FLAGS[TPL_DOT];
   endproperty
   a_dot_trip: assert property (p_dot_trip)
      else $error("discharge overtemp did not trip after delay");

   property p_die_rec;
      @(posedge REF_CLK) disable iff (RST)
      EVAL_TICK && fault_reg[TPL_DIE] && cfg_reg[TPL_DIE].recovery != 8'h00
      && DIE_TEMP_CODE <= CODE_W'(cfg_reg[TPL_DIE].recovery)
      |=> !FAULT_FLAGS[TPL_DIE];
   endproperty
   a_die_rec: assert property (p_die_rec)
      else $error("die overtemp did not recover");

   property p_host_rec;
      @(posedge REF_CLK) disable iff (RST)
      temp_recovery_cmd && !EVAL_TICK |=> FAULT_FLAGS == 3'h0;
   endproperty
   a_host_rec: assert property (p_host_rec)
      else $error("recovery command left a fault latched");

   property p_cut_alert;
      @(posedge REF_CLK) disable iff (RST)
      EVAL_TICK && !(THERMISTOR_SENSE_CODE > CODE_W'(cfg_reg[TPL_CUT].trip))
      |=> !ALERT_FLAGS[TPL_CUT];
   endproperty
   a_cut_alert: assert property (p_cut_alert)
      else $error("charge undertemp alert without condition");
endmodule : tpl_temp_protect

/* tpl_ntc_model.sv */
// front-end model: ntc thermistor sense code and die temperature readings
module tpl_ntc_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic [7:0] sense_level,
   input wire logic [7:0] die_level,
   output logic window,
   output logic tick,
   output logic [7:0] sense_code,
   output logic [7:0] die_code
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_reg;
   // a conversion spans three cycles and its result is valid in the last
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 2'h0;
      end else if (req && cnt_reg == 2'h0) begin
         cnt_reg <= 2'h3;
      end else if (cnt_reg != 2'h0) begin
         cnt_reg <= cnt_reg - 2'h1;
      end
   end
   assign window = cnt_reg != 2'h0;
   assign tick = cnt_reg == 2'h1;
   // codes are not held outside the result cycle, so show the inverse
   assign sense_code = tick ? sense_level : ~sense_level;
   assign die_code = tick ? die_level : ~die_level;
endmodule : tpl_ntc_model

/* testbench.sv */
// self-checking bench of the temperature protection block
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin \
   bad_count++; $display("CHECK FAILED t=%0t %s", $time, msg); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import tpl_pkg::*;
   typedef struct packed {
      logic [7:0] sense;
      logic [7:0] die;
      logic [7:0] res;
   } tpl_row_t;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err, req;
   logic win, tick, bias, dsg_off, chg_off;
   logic [7:0] paddr, sense_lvl, die_lvl, sense_code, die_code;
   logic [31:0] pwdata, prdata, rdata;
   logic [2:0] alerts, faults;
   int bad_count = 0;
   int num_checks = 0;
   // res: alert[7:5] fault[4:2] discharge cut[1] charge cut[0]
   tpl_row_t rows [17] = '{24'h802000, 24'h402000, 24'h3F2020, 24'h802000,
      24'h3F2020, 24'h3F2006, 24'h4F2006, 24'h502000, 24'h80650B,
      24'h805B0B, 24'h805A00, 24'hC02000, 24'hC12080, 24'hC12080,
      24'hC12011, 24'hB12011, 24'hB02000};

   tpl_temp_protect #(.CODE_W(8)) i_tpl_temp_protect (.REF_CLK(clk),
      .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .EVAL_WINDOW(win), .EVAL_TICK(tick),
      .THERMISTOR_SENSE_CODE(sense_code), .DIE_TEMP_CODE(die_code),
      .THERMISTOR_BIAS_EN(bias), .DISCHARGE_FET_DRIVE_OFF(dsg_off),
      .CHARGE_FET_DRIVE_OFF(chg_off), .ALERT_FLAGS(alerts),
      .FAULT_FLAGS(faults));
   tpl_ntc_model i_tpl_ntc_model (.clk(clk), .rst(rst), .req(req),
      .sense_level(sense_lvl), .die_level(die_lvl), .window(win),
      .tick(tick), .sense_code(sense_code), .die_code(die_code));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   // one apb transfer; the request stands until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdata = prdata;
      err = pslverr;
      `CHK(pready, 1'b1, "no apb answer")
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      `CHK(rdata, exp, "register read")
   endtask : rd_chk

   // one evaluation interval; flags are compared two cycles after the tick
   task automatic eval(input logic [7:0] s, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      sense_lvl <= s;
      die_lvl <= d;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (tick !== 1'b1 && n < 10);
      `CHK(tick, 1'b1, "no evaluation tick")
      `CHK(bias, 1'b1, "pullup not biased while evaluating")
      repeat (2) @(negedge clk);
   endtask : eval

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      close_out();
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      req = 1'b0;
      sense_lvl = 8'h80;
      die_lvl = 8'h20;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK({alerts, faults, dsg_off, chg_off, bias}, 9'h000, "reset outputs")
      for (int a = 0; a < 32; a += 4) begin
         rd_chk(a[7:0], 32'h00000000);
      end
      apb(1'b0, 8'h20, 32'h00000000);
      `CHK({err, rdata}, 33'h100000000, "unmapped read")
      apb(1'b1, TPL_OFS_STATUS, 32'hFFFFFFFF);
      rd_chk(TPL_OFS_STATUS, 32'h00000000);
      apb(1'b1, TPL_OFS_PROT_EN, 32'hFFFFFFFF);
      rd_chk(TPL_OFS_PROT_EN, 32'h00000007);
      apb(1'b1, TPL_OFS_DSG_FET, 32'h00000003);
      apb(1'b1, TPL_OFS_CHG_FET, 32'h00000003);
      apb(1'b1, TPL_OFS_DOT_CFG, 32'h00015040);
      apb(1'b1, TPL_OFS_DIE_CFG, 32'h00005A64);
      apb(1'b1, TPL_OFS_CUT_CFG, 32'h02B0C0FF);
      rd_chk(TPL_OFS_CUT_CFG, 32'h00B0C0FF);
      apb(1'b1, TPL_OFS_CUT_CFG, 32'h0002B0C0);
      $display("test registers done");
      for (int i = 0; i < 17; i++) begin
         eval(rows[i].sense, rows[i].die);
         `CHK({alerts, faults, dsg_off, chg_off}, rows[i].res, "row")
      end
      `CHK(bias, 1'b0, "pullup biased while idle")
      $display("test evaluation rows done");
      apb(1'b1, TPL_OFS_PROT_EN, 32'h00000000);
      eval(8'h00, 8'hFF);
      `CHK({alerts, faults}, 6'h00, "disabled low sense")
      eval(8'hFF, 8'hFF);
      `CHK({alerts, faults}, 6'h00, "disabled high sense")
      $display("test disabled done");
      apb(1'b1, TPL_OFS_DSG_FET, 32'h00000000);
      apb(1'b1, TPL_OFS_PROT_EN, 32'h00000001);
      apb(1'b1, TPL_OFS_DOT_CFG, 32'h00000040);
      eval(8'h3F, 8'h20);
      `CHK({alerts, faults, dsg_off}, 7'h02, "trip without fet")
      eval(8'hFF, 8'h20);
      `CHK(faults, 3'h1, "zero recovery must hold")
      apb(1'b1, TPL_OFS_CMD, 32'h0001009B);
      repeat (2) @(negedge clk);
      `CHK(faults, 3'h0, "recovery command")
      $display("test host recovery done");
      apb(1'b1, TPL_OFS_CMD, 32'h00010069);
      repeat (2) @(negedge clk);
      `CHK(bias, 1'b1, "continuous bias")
      rd_chk(TPL_OFS_STATUS, 32'h00040000);
      $display("test continuous bias done");
      eval(8'h00, 8'h20);
      `CHK(faults, 3'h1, "fault before reset")
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK({alerts, faults, dsg_off, chg_off, bias}, 9'h000, "mid-run reset")
      rd_chk(TPL_OFS_PROT_EN, 32'h00000000);
      eval(8'h00, 8'hFF);
      `CHK({alerts, faults, bias}, 7'h00, "reset cleared enables")
      $display("test mid-run reset done");
      close_out();
   end
endmodule : testbench
